// *** drg_core.v ***
// Purpose: digital ramp generator core with apb registers
// Assumes: apb3 slave, 10 MHz clk_sys_in, sync reset
// Notes:   dds clock is an enable every fourth clock
`timescale 1ns/10ps
`include "drg_defines.vh"
module drg_core #(
  parameter ACC_W  = 32, // accumulator width
  parameter TIME_W = 16  // interval timer width
) (
  input  wire        clk_sys_in,       // system clock
  input  wire        rst_in,           // sync reset, active high
  input  wire        psel,             // apb select
  input  wire        penable,          // apb enable
  input  wire        pwrite,           // apb direction
  input  wire [11:0] paddr,            // apb byte address
  input  wire [31:0] pwdata,           // apb write data
  output wire        pready,           // apb ready, always high
  output reg  [31:0] prdata,           // apb read data
  output wire        pslverr,          // apb error on unmapped
  input  wire        update_strobe_in, // update strobe pin
  input  wire        ramp_direction_pin_in, // 1 up, 0 down
  input  wire        ramp_hold_pin_in, // 1 stalls ramp
  output reg         ramp_limit_flag_pin_out, // at bound
  output reg  [31:0] freq_out,         // frequency destination
  output reg  [15:0] phase_out,        // phase destination
  output reg  [13:0] ampl_out,         // amplitude destination
  output reg  [1:0]  dest_out          // registered destination
);
  // software-written shadow copies
  reg [31:0]       ctrl_reg;
  reg [31:0]       rate_reg;
  reg [ACC_W-1:0]  step_pos_reg;
  reg [ACC_W-1:0]  step_neg_reg;
  reg [ACC_W-1:0]  lim_up_reg;
  reg [ACC_W-1:0]  lim_lo_reg;
  reg              sw_strobe_reg;
  // registered control, live after a strobe
  reg              en_reg;
  reg              clr_reg;
  reg              ndw_hi_reg;
  reg              ndw_lo_reg;
  reg              flag_en_reg;
  reg              aclr_reg;
  reg              aclr_pend_reg;
  reg              reload_pend_reg;
  // datapath state
  reg [ACC_W-1:0]  acc_reg;
  reg [TIME_W-1:0] timer_reg;
  reg [1:0]        div_reg;
  reg              dir_d_reg;
  reg              strobe_d_reg;
  wire             dir_s;
  wire             hold_s;
  wire             strobe_s;
  wire             wr_en;
  wire             rd_en;
  wire             strobe_rise;
  wire             dds_tick;
  wire             dir_change;
  wire [TIME_W-1:0] interval;
  wire [ACC_W:0]   sum_up;
  wire [ACC_W:0]   diff_dn;
  wire             at_up;
  wire             at_lo;
  wire [1:0]       dest_sel;
  reg  [ACC_W-1:0] acc_next;
  reg              mapped;

  // pins resynchronised before they touch state
  drg_sync u_dir (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .d_in       (ramp_direction_pin_in),
    .q_out      (dir_s)
  );
  drg_sync u_hold (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .d_in       (ramp_hold_pin_in),
    .q_out      (hold_s)
  );
  drg_sync u_strb (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .d_in       (update_strobe_in),
    .q_out      (strobe_s)
  );

  // zero-wait apb slave
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pslverr = psel & penable & ~mapped;

  // address decode and read mux
  always @* begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      `DRG_OFF_CTRL:     prdata = ctrl_reg;
      `DRG_OFF_RATE:     prdata = rate_reg;
      `DRG_OFF_STEP_POS: prdata = step_pos_reg;
      `DRG_OFF_STEP_NEG: prdata = step_neg_reg;
      `DRG_OFF_LIM_UP:   prdata = lim_up_reg;
      `DRG_OFF_LIM_LO:   prdata = lim_lo_reg;
      `DRG_OFF_STROBE:   prdata = 32'h0000_0000;
      `DRG_OFF_STATUS:   prdata = {24'h00_0000, ndw_lo_reg, ndw_hi_reg, at_lo, at_up,
                                   dir_s, hold_s, clr_reg, en_reg};
      `DRG_OFF_OUT:      prdata = acc_reg;
      default:           mapped = 1'b0;
    endcase
    if (!rd_en) begin
      prdata = 32'h0000_0000;
    end
  end

  // register writes; strobe register gives software an update too
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_reg      <= `DRG_CTRL_RESET;
      rate_reg      <= 32'h0000_0000;
      step_pos_reg  <= {ACC_W{1'b0}};
      step_neg_reg  <= {ACC_W{1'b0}};
      lim_up_reg    <= {ACC_W{1'b1}};
      lim_lo_reg    <= {ACC_W{1'b0}};
      sw_strobe_reg <= 1'b0;
    end else begin
      sw_strobe_reg <= wr_en && (paddr == `DRG_OFF_STROBE) && pwdata[0];
      if (wr_en) begin
        case (paddr)
          `DRG_OFF_CTRL:     ctrl_reg     <= pwdata;
          `DRG_OFF_RATE:     rate_reg     <= pwdata;
          `DRG_OFF_STEP_POS: step_pos_reg <= pwdata[ACC_W-1:0];
          `DRG_OFF_STEP_NEG: step_neg_reg <= pwdata[ACC_W-1:0];
          `DRG_OFF_LIM_UP:   lim_up_reg   <= pwdata[ACC_W-1:0];
          `DRG_OFF_LIM_LO:   lim_lo_reg   <= pwdata[ACC_W-1:0];
          default:           ;
        endcase
      end
    end
  end

  // edge detect on the synchronised second stage only
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      strobe_d_reg <= 1'b0;
      dir_d_reg    <= 1'b0;
    end else begin
      strobe_d_reg <= strobe_s;
      dir_d_reg    <= dir_s;
    end
  end
  assign strobe_rise = (strobe_s & ~strobe_d_reg) | sw_strobe_reg;
  assign dir_change  = dir_s ^ dir_d_reg;

  // dds clock enable, one system clock in four; parked while disabled
  always @(posedge clk_sys_in) begin
    if (rst_in || !en_reg) begin
      div_reg <= 2'd0;
    end else begin
      div_reg <= div_reg + 2'd1;
    end
  end
  assign dds_tick = en_reg && (div_reg == `DRG_DDS_DIV);

  // control bits latch only on an update strobe
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      en_reg          <= 1'b0;
      clr_reg         <= 1'b0;
      aclr_reg        <= 1'b0;
      ndw_hi_reg      <= 1'b0;
      ndw_lo_reg      <= 1'b0;
      flag_en_reg     <= 1'b0;
      dest_out        <= 2'b00;
      aclr_pend_reg   <= 1'b0;
      reload_pend_reg <= 1'b0;
    end else begin
      if (strobe_rise) begin
        en_reg      <= ctrl_reg[`DRG_BIT_ENABLE];
        clr_reg     <= ctrl_reg[`DRG_BIT_CLEAR];
        aclr_reg    <= ctrl_reg[`DRG_BIT_AUTOCLR];
        ndw_hi_reg  <= ctrl_reg[`DRG_BIT_NDW_HI];
        ndw_lo_reg  <= ctrl_reg[`DRG_BIT_NDW_LO];
        flag_en_reg <= ctrl_reg[`DRG_BIT_FLAG_EN];
        dest_out    <= {ctrl_reg[`DRG_BIT_DEST1], ctrl_reg[`DRG_BIT_DEST0]};
      end
      // pending events wait for the next dds tick; set beats clear
      if (strobe_rise && ctrl_reg[`DRG_BIT_AUTOCLR]) begin
        aclr_pend_reg <= 1'b1;
      end else if (dds_tick) begin
        aclr_pend_reg <= 1'b0;
      end
      if ((strobe_rise && ((ctrl_reg[`DRG_BIT_ENABLE] && !en_reg) ||
                           ctrl_reg[`DRG_BIT_RELOAD])) ||
          (en_reg && dir_change)) begin
        reload_pend_reg <= 1'b1;
      end else if (dds_tick) begin
        reload_pend_reg <= 1'b0;
      end
    end
  end

  // interval and step selected by direction
  assign interval = dir_s ? rate_reg[15:0] : rate_reg[31:16];
  assign sum_up   = {1'b0, acc_reg} + {1'b0, step_pos_reg};
  assign diff_dn  = {1'b0, acc_reg} - {1'b0, step_neg_reg};
  assign at_up    = (acc_reg == lim_up_reg);
  assign at_lo    = (acc_reg == lim_lo_reg);

  // next accumulator value, clamped in the feedback path
  always @* begin
    acc_next = acc_reg;
    if (clr_reg || aclr_pend_reg) begin
      acc_next = lim_lo_reg;
    end else if (hold_s) begin
      acc_next = acc_reg;
    end else if (timer_reg == {TIME_W{1'b0}}) begin
      if (dir_s) begin
        // overflow or passing the bound sticks at upper limit
        if (sum_up[ACC_W] || sum_up[ACC_W-1:0] > lim_up_reg) begin
          acc_next = lim_up_reg;
        end else begin
          acc_next = sum_up[ACC_W-1:0];
        end
      end else begin
        if (diff_dn[ACC_W] || diff_dn[ACC_W-1:0] < lim_lo_reg) begin
          acc_next = lim_lo_reg;
        end else begin
          acc_next = diff_dn[ACC_W-1:0];
        end
      end
    end
    // no-dwell bits are only stored and read back; bounds always dwell
    // reprogrammed limits pull the value back inside
    if (acc_next > lim_up_reg) begin
      acc_next = lim_up_reg;
    end
    if (acc_next < lim_lo_reg) begin
      acc_next = lim_lo_reg;
    end
  end

  // accumulator and timer step on dds ticks; an enabling strobe while ramping down loads lim_lo_reg at once
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc_reg   <= {ACC_W{1'b0}};
      timer_reg <= {TIME_W{1'b0}};
    end else if (strobe_rise && ctrl_reg[`DRG_BIT_ENABLE] && !en_reg && !dir_s) begin
      acc_reg   <= lim_lo_reg;
    end else if (dds_tick) begin
      acc_reg <= acc_next;
      if (reload_pend_reg || timer_reg == {TIME_W{1'b0}}) begin
        timer_reg <= (interval == {TIME_W{1'b0}}) ? {TIME_W{1'b0}} :
                     interval - {{(TIME_W-1){1'b0}}, 1'b1};
      end else if (!hold_s) begin
        timer_reg <= timer_reg - {{(TIME_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // new destination applies on the edge that updates dest_out, so they never disagree
  assign dest_sel = strobe_rise ? {ctrl_reg[`DRG_BIT_DEST1], ctrl_reg[`DRG_BIT_DEST0]} :
                    dest_out;

  // destination routing and limit flag
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      freq_out                <= 32'h0000_0000;
      phase_out               <= 16'h0000;
      ampl_out                <= 14'h0000;
      ramp_limit_flag_pin_out <= 1'b0;
    end else begin
      freq_out  <= (dest_sel == 2'b00) ? acc_reg : 32'h0000_0000;
      phase_out <= (dest_sel == 2'b01) ? acc_reg[31:16] : 16'h0000;
      ampl_out  <= dest_sel[1] ? acc_reg[31:18] : 14'h0000;
      ramp_limit_flag_pin_out <= flag_en_reg && en_reg && (at_up || at_lo);
    end
  end
endmodule

// *** drg_defines.vh ***
// Purpose: constants for the ramp generator core
// Assumes: apb byte addresses, 32-bit data
// Notes:   offsets and bit positions are local choices
`ifndef DRG_DEFINES_VH
`define DRG_DEFINES_VH
`define DRG_OFF_CTRL      12'h000
`define DRG_OFF_RATE      12'h004
`define DRG_OFF_STEP_POS  12'h008
`define DRG_OFF_STEP_NEG  12'h00C
`define DRG_OFF_LIM_UP    12'h010
`define DRG_OFF_LIM_LO    12'h014
`define DRG_OFF_STROBE    12'h018
`define DRG_OFF_STATUS    12'h01C
`define DRG_OFF_OUT       12'h020
`define DRG_BIT_ENABLE    0
`define DRG_BIT_CLEAR     1
`define DRG_BIT_AUTOCLR   2
`define DRG_BIT_RELOAD    3
`define DRG_BIT_NDW_HI    4
`define DRG_BIT_NDW_LO    5
`define DRG_BIT_FLAG_EN   6
`define DRG_BIT_DEST0     8
`define DRG_BIT_DEST1     9
`define DRG_CTRL_RESET    32'h0000_0000
`define DRG_DDS_DIV       2'd3
`endif

// *** drg_sync.v ***
// Purpose: two flop synchroniser for one level
// Assumes: single clock, synchronous reset
// Notes:   first stage read only by the second
`timescale 1ns/10ps
module drg_sync (
  input  wire clk_sys_in, // system clock
  input  wire rst_in,     // sync reset, active high
  input  wire d_in,       // async level
  output reg  q_out       // synchronised level
);
  reg meta_reg;
  // two stages to settle metastability
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// *** drg_core_properties.sv ***
// Purpose: port checks for the ramp core
// Assumes: dest 00 routes the ramp to freq_out
// Notes:   long strobe pulses keep its effect inside the disable window
`timescale 1ns/10ps
module drg_core_properties (
  input wire        clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata, freq_out,
  input wire        update_strobe_in, ramp_direction_pin_in, ramp_hold_pin_in,
  input wire        ramp_limit_flag_pin_out,
  input wire [15:0] phase_out,
  input wire [13:0] ampl_out,
  input wire [1:0]  dest_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  // hold with no bus or strobe traffic around it
  sequence s_hold_quiet;
    (ramp_hold_pin_in && !psel && !update_strobe_in) [*6];
  endsequence
  sequence s_step;
    $changed(freq_out) && dest_out == 2'b00;
  endsequence
  a_reset_clears: assert property (rst_in |=> freq_out == 32'h0000_0000 && dest_out == 2'b00)
    else $error("outputs not cleared");
  a_flag_reset: assert property (rst_in |=> !ramp_limit_flag_pin_out)
    else $error("flag not cleared");
  a_ready_high: assert property (disable iff (rst_in) pready) else $error("ready low");
  a_err_unmapped: assert property (disable iff (rst_in)
    psel && penable |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 12'h020))
    else $error("slverr wrong");
  a_read_idle: assert property (disable iff (rst_in)
    !(psel && penable && !pwrite) |-> prdata == 32'h0000_0000) else $error("prdata not 0");
  a_dest_freq: assert property (disable iff (rst_in)
    dest_out == 2'b00 |-> phase_out == 16'h0000 && ampl_out == 14'h0000) else $error("freq route");
  a_dest_phase: assert property (disable iff (rst_in)
    dest_out == 2'b01 |-> freq_out == 32'h0000_0000 && ampl_out == 14'h0000)
    else $error("phase route");
  a_dest_ampl: assert property (disable iff (rst_in)
    dest_out[1] |-> freq_out == 32'h0000_0000 && phase_out == 16'h0000) else $error("ampl route");
  a_hold_freeze: assert property (disable iff (rst_in)
    s_hold_quiet |-> $stable(freq_out) && $stable(phase_out)) else $error("moved in hold");
  // steps only on dds ticks, four clocks apart
  a_tick_spacing: assert property (disable iff (rst_in || psel || update_strobe_in)
    s_step |=> !$changed(freq_out) [*3]) else $error("step off tick");
endmodule
bind drg_core drg_core_properties u_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .freq_out(freq_out),
  .update_strobe_in(update_strobe_in), .ramp_direction_pin_in(ramp_direction_pin_in),
  .ramp_hold_pin_in(ramp_hold_pin_in), .ramp_limit_flag_pin_out(ramp_limit_flag_pin_out),
  .phase_out(phase_out), .ampl_out(ampl_out), .dest_out(dest_out));

// *** drg_host_model.sv ***
// Purpose: host side pins of the ramp core
// Assumes: pins change right after rising edges
// Notes:   strobe held six clocks, well past the sync delay
`timescale 1ns/10ps
module drg_host_model (
  input  wire  clk_sys_in, // system clock
  output logic strobe_out, // update strobe
  output logic dir_out,    // 1 ramps up
  output logic hold_out    // 1 freezes ramp
);
  // idle levels from time zero
  initial begin
    strobe_out = 1'b0;
    dir_out = 1'b0;
    hold_out = 1'b0;
  end
  // one strobe registers all pending control bits
  task strobe();
    @(posedge clk_sys_in);
    strobe_out <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    strobe_out <= 1'b0;
  endtask
  task set_pins(input logic d, input logic h);
    @(posedge clk_sys_in);
    dir_out <= d;
    hold_out <= h;
  endtask
endmodule

// *** test_digital_ramp_generator_core.sv ***
// Purpose: self-checking bench for the ramp core
// Assumes: frequency destination until the routing test
// Notes:   limits kept upper above lower throughout
`timescale 1ns/10ps
module test_digital_ramp_generator_core;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, v0, v1;
  wire         pready, pslverr, strobe, dir, hold, flag;
  wire  [31:0] prdata, freq;
  wire  [15:0] phase;
  wire  [13:0] ampl;
  wire  [1:0]  dest;
  int          n_errors = 0, total_checks = 0, n;
  logic [11:0] ra [6] = '{12'h004, 12'h008, 12'h00C, 12'h014, 12'h010, 12'h024};
  logic [31:0] rv [6] = '{32'h0001_0002, 32'h0000_0020, 32'h0000_0008, 32'h0000_0010,
                          32'h0000_0100, 32'h1234_5678};
  logic        re [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  always #50 clk_sys_in = ~clk_sys_in;
  drg_core uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .update_strobe_in(strobe), .ramp_direction_pin_in(dir),
    .ramp_hold_pin_in(hold), .ramp_limit_flag_pin_out(flag), .freq_out(freq),
    .phase_out(phase), .ampl_out(ampl), .dest_out(dest));
  drg_host_model host (.clk_sys_in(clk_sys_in), .strobe_out(strobe), .dir_out(dir),
    .hold_out(hold));
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t apb ready timeout", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ctl(input logic [31:0] c);
    apb(1'b1, 12'h000, c);
    host.strobe();
  endtask
  task wait_val(input logic [31:0] e);
    n = 0;
    while (freq !== e && n < 3000) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk(freq, e);
  endtask
  task wait_chg();
    logic [31:0] s;
    s = freq;
    n = 0;
    while (freq === s && n < 500) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
  endtask
  // two steps: value change and spacing in clocks
  task meas();
    wait_chg();
    v0 = freq;
    wait_chg();
    v1 = freq;
  endtask
  task idle(input int c);
    repeat (c) @(posedge clk_sys_in);
    #1;
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cut a hang short well past the expected run
  initial begin
    #6_000_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    idle(2);
    rst_in <= 1'b0;
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, 32'hFFFF_FFFF);
    chk(freq, 32'h0000_0000);
    // table rows: write, then read back; unmapped refused
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ra[i], rv[i]);
      chk({31'h0, er}, {31'h0, re[i]});
      apb(1'b0, ra[i], 32'h0000_0000);
      chk(rd, re[i] ? 32'h0000_0000 : rv[i]);
    end
    $display("done registers");
    apb(1'b1, 12'h000, 32'h0000_0001);
    idle(20);
    chk(freq, 32'h0000_0000);
    host.strobe();
    wait_val(32'h0000_0010);
    host.set_pins(1'b1, 1'b0);
    meas();
    chk(v1 - v0, 32'h0000_0020);
    chk(n, 8);
    wait_val(32'h0000_0100);
    idle(40);
    chk(freq, 32'h0000_0100);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk(rd, 32'h0000_0019);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(rd, 32'h0000_0100);
    host.set_pins(1'b0, 1'b0);
    meas();
    chk(v0 - v1, 32'h0000_0008);
    chk(n, 4);
    host.set_pins(1'b0, 1'b1);
    idle(8);
    v0 = freq;
    idle(30);
    chk(freq, v0);
    host.set_pins(1'b0, 1'b0);
    wait_val(32'h0000_0010);
    idle(40);
    chk(freq, 32'h0000_0010);
    $display("done slopes");
    host.set_pins(1'b1, 1'b0);
    idle(20);
    ctl(32'h0000_0003);
    wait_val(32'h0000_0010);
    idle(40);
    chk(freq, 32'h0000_0010);
    ctl(32'h0000_0001);
    wait_val(32'h0000_0030);
    wait_val(32'h0000_0100);
    ctl(32'h0000_0005);
    wait_val(32'h0000_0030);
    // reload bit: software strobes faster than the interval keep the ramp still
    apb(1'b1, 12'h004, 32'h0001_0010);
    apb(1'b1, 12'h000, 32'h0000_0009);
    apb(1'b1, 12'h018, 32'h0000_0001);
    apb(1'b1, 12'h018, 32'h0000_0001);
    idle(3);
    v0 = freq;
    for (int i = 0; i < 30; i++) begin
      apb(1'b1, 12'h018, 32'h0000_0001);
    end
    idle(1);
    chk(freq, v0);
    apb(1'b1, 12'h004, 32'h0001_0002);
    $display("done clear");
    wait_val(32'h0000_0100);
    ctl(32'h0000_0041);
    idle(4);
    chk(flag, 32'h0000_0001);
    host.set_pins(1'b0, 1'b0);
    idle(16);
    chk(flag, 32'h0000_0000);
    host.set_pins(1'b1, 1'b0);
    apb(1'b1, 12'h008, 32'h0001_0000);
    apb(1'b1, 12'h010, 32'h0004_0000);
    wait_val(32'h0004_0000);
    // each destination code in turn
    for (int d = 1; d < 4; d++) begin
      ctl({22'h0, d[1:0], 8'h01});
      idle(4);
      chk({30'h0, dest}, d);
      chk({phase, 2'b00, ampl}, d == 1 ? 32'h0004_0000 : 32'h0000_0001);
    end
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h018, 32'h0000_0001);
    idle(4);
    chk(freq, 32'h0004_0000);
    $display("done routing");
    end_of_test();
  end
endmodule
